// File: include/seq_pkg.sv
// constants, modes and carrier types for the start-up and fault sequencer
// assumes one 100 MHz clock; voltages are 12-bit codes, temperatures are degrees C
package seq_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          VW               = 12;
    localparam int          CW               = 24;
    // register offsets
    localparam logic [3:0]  REG_CTRL         = 4'h0;
    localparam logic [3:0]  REG_TARGET       = 4'h1;
    localparam logic [3:0]  REG_OV_LIMIT     = 4'h2;
    localparam logic [3:0]  REG_START_DLY    = 4'h3;
    localparam logic [3:0]  REG_RAMP_TIME    = 4'h4;
    localparam logic [3:0]  REG_OC_CFG       = 4'h5;
    localparam logic [3:0]  REG_OT_CFG       = 4'h6;
    localparam logic [3:0]  REG_OV_CFG       = 4'h7;
    localparam logic [3:0]  REG_OT_LIMIT     = 4'h8;
    localparam logic [3:0]  REG_TRACK_CFG    = 4'h9;
    localparam logic [3:0]  REG_STATUS       = 4'hA;
    localparam logic [3:0]  REG_REF          = 4'hB;
    // ctrl field positions
    localparam int          CTRL_SHARE_BIT   = 0;
    // track cfg field positions
    localparam int          TRK_EN_BIT       = 0;
    localparam int          TRK_RATIO_BIT    = 1;
    localparam int          TRK_PCT_LSB      = 8;
    // fault cfg fields: policy [2:0], retry count [7:4], delay in ms [15:8]
    localparam int          FC_CNT_LSB       = 4;
    localparam int          FC_DLY_LSB       = 8;
    // reset values
    localparam logic [VW-1:0] TARGET_RST     = 12'h800;
    localparam logic [VW-1:0] OV_LIMIT_RST   = 12'h933;
    localparam logic [15:0] START_DLY_RST    = 16'h000A;
    localparam logic [15:0] RAMP_TIME_RST    = 16'h0005;
    localparam logic [7:0]  OT_LIMIT_RST     = 8'h7D;
    localparam logic [7:0]  OT_HYST_C        = 8'h0F;
    localparam logic [6:0]  TRK_PCT_RST      = 7'h40;   // half, in 128ths
    // timing: one tick per millisecond
    localparam int          MS_NS            = 1000000;
    localparam int          MS_CYC           = MS_NS * CLK_MHZ / 1000;
    typedef enum logic [2:0] {
        POL_IMMEDIATE, POL_RETRY_INF, POL_RETRY_CNT, POL_DELAY_OFF, POL_IGNORE
    } policy_t;
    typedef enum logic [2:0] {
        ST_OFF, ST_DELAY, ST_RAMP, ST_HOLD, ST_SETTLE, ST_RUN, ST_FAULT, ST_LATCHED
    } seq_state_t;
    typedef struct packed {
        logic [7:0] dly_ms;
        logic [3:0] count;
        logic       pad;
        logic [2:0] policy;
    } fault_cfg_t;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;
    typedef struct packed {
        logic high_off;
        logic low_off;
    } drive_t;
    localparam fault_cfg_t  FC_RST           = 16'h0000;
endpackage

// File: sim/conv_plant.sv
// output stage stand-in: holds an imposed level while idle, follows the target when the high side is driven
// assumes drive enables and target come straight from the sequencer
`timescale 1ns/1ps
module conv_plant
    import seq_pkg::*;
(
    // sequencer drive
    input  wire logic          high_drive_en,
    input  wire logic          low_drive_en,
    input  wire logic [VW-1:0] vref_out,
    // imposed pre-bias and sensed output
    input  wire logic [VW-1:0] pre_v,
    output logic [VW-1:0]      vout_sense
);
    // low side alone pulls the output down; no ideal loop delay is modelled
    assign vout_sense = high_drive_en ? vref_out : (low_drive_en ? 12'h000 : pre_v);
endmodule

// File: sim/prebias_fault_tracking_seq_tb_top.sv
// bench for the start-up sequencer: registers, pre-bias, overcurrent, tracking
// assumes the plant model on the converter side and the checker bound below
`timescale 1ns/1ps
module prebias_fault_tracking_seq_tb_top
    import seq_pkg::*;
;
    logic          clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, probe = 1'b0;
    logic          enable_in = 1'b0, overcurrent_in = 1'b0;
    logic [3:0]    reg_addr = 4'h0;
    logic [15:0]   reg_wdata = 16'h0000, reg_rdata, v, r;
    logic [VW-1:0] vout_sense, vref_out, trk_ref = 12'h000, pre_v = 12'h000;
    logic          high_drive_en, low_drive_en, power_good_out;
    logic [31:0]   notes[$];
    logic [1:0]    pend = 2'b00;
    logic [7:0]    temp = 8'h19;
    int            err_total = 0, tests_run = 0, cyc = 0, n, m;
    // 100 MHz clock
    always #5 clk = ~clk;
    prebias_fault_tracking_seq uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .enable_in(enable_in), .vout_sense(vout_sense), .tracking_reference_in(trk_ref),
        .die_temp(temp), .overcurrent_in(overcurrent_in), .vref_out(vref_out),
        .high_drive_en(high_drive_en), .low_drive_en(low_drive_en),
        .power_good_out(power_good_out));
    conv_plant plant (.high_drive_en(high_drive_en), .low_drive_en(low_drive_en),
        .vref_out(vref_out), .pre_v(pre_v), .vout_sense(vout_sense));
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus cycle; strobes stay up so cycles can follow back to back
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) notes.push_back({16'hFFFF, d});
        @(posedge clk);
    endtask
    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    // note a masked expectation on the converter outputs
    task automatic look(input logic [15:0] mk, input logic [15:0] e);
        probe <= 1'b1;
        notes.push_back({mk, e});
        @(posedge clk);
        probe <= 1'b0;
        @(posedge clk);
    endtask
    // monitor: the oldest note is compared with the slot that shows now
    always @(posedge clk) begin
        if (pend != 2'b00) begin
            v = pend[0] ? reg_rdata :
                {power_good_out, high_drive_en, low_drive_en, 1'b0, vref_out};
            check(v & notes[0][31:16], notes[0][15:0]);
            void'(notes.pop_front());
        end
        pend <= {probe, reg_rd};
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32755));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values, then the unmapped hole
        bus(0, REG_TARGET, {4'h0, TARGET_RST});
        bus(0, REG_OV_LIMIT, {4'h0, OV_LIMIT_RST});
        bus(0, REG_START_DLY, START_DLY_RST);
        bus(0, REG_RAMP_TIME, RAMP_TIME_RST);
        bus(0, REG_OT_LIMIT, {8'h00, OT_LIMIT_RST});
        bus(0, REG_TRACK_CFG, {1'b0, TRK_PCT_RST, 8'h00});
        for (n = 12; n < 16; n++) bus(0, n[3:0], 16'h0000);
        // random targets written and read straight back
        for (n = 0; n < 4; n++) begin
            r = 16'($urandom) & 16'h0FFF;
            bus(1, REG_TARGET, r);
            bus(0, REG_TARGET, r);
        end
        bus(1, REG_TARGET, 16'h0800);
        bus(1, REG_START_DLY, 16'h0000);
        bus(1, REG_RAMP_TIME, 16'h0000);
        idle();
        // pre-bias below target, then an overcurrent and its recovery
        pre_v <= 12'h400;
        enable_in <= 1'b1;
        for (n = 0; n < 3000 && power_good_out !== 1'b1; n++) @(posedge clk);
        look(16'hEFFF, 16'hE800);
        overcurrent_in <= 1'b1;
        repeat (20) @(posedge clk);
        look(16'hC000, 16'h0000);
        overcurrent_in <= 1'b0;
        for (n = 0; n < 3000 && power_good_out !== 1'b1; n++) @(posedge clk);
        look(16'h8000, 16'h8000);
        // overheat, then cool
        temp <= 8'h7E;
        repeat (20) @(posedge clk);
        look(16'hC000, 16'h0000);
        temp <= 8'h6F;
        repeat (20) @(posedge clk);
        look(16'hC000, 16'h0000);
        temp <= 8'h6D;
        repeat (20) @(posedge clk);
        look(16'hC000, 16'hC000);
        enable_in <= 1'b0;
        pre_v <= 12'hF00;
        repeat (50) @(posedge clk);
        // pre-bias over the limit must never start
        enable_in <= 1'b1;
        repeat (300) @(posedge clk);
        look(16'hE000, 16'h0000);
        enable_in <= 1'b0;
        pre_v <= 12'h000;
        repeat (50) @(posedge clk);
        // both tracking modes; the long start delay must be ignored
        bus(1, REG_START_DLY, START_DLY_RST);
        for (m = 0; m < 2; m++) begin
            bus(1, REG_TRACK_CFG, {8'h40, 6'h00, m[0], 1'b1});
            idle();
            enable_in <= 1'b1;
            trk_ref <= 12'h500;
            for (n = 0; n < 3000 && high_drive_en !== 1'b1; n++) @(posedge clk);
            repeat (50) @(posedge clk);
            look(16'h4FFF, m[0] ? 16'h4280 : 16'h4500);
            enable_in <= 1'b0;
            trk_ref <= 12'h000;
            repeat (100) @(posedge clk);
        end
        test_done();
    end
endmodule
bind prebias_fault_tracking_seq seq_assertions chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .enable_in(enable_in), .overcurrent_in(overcurrent_in), .high_drive_en(high_drive_en),
    .low_drive_en(low_drive_en), .power_good_out(power_good_out));

// File: sim/seq_assertions.sv
// port checker for the start-up sequencer
// assumes a bind from the bench top; one clock domain
`timescale 1ns/1ps
module seq_assertions
    import seq_pkg::*;
(
    // clock, reset, register port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // converter side
    input wire logic        enable_in,
    input wire logic        overcurrent_in,
    input wire logic        high_drive_en,
    input wire logic        low_drive_en,
    input wire logic        power_good_out
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // reset itself is watched here, so this one is never disabled
    reset_quiet_a: assert property (disable iff (1'b0)
        rst |=> !high_drive_en && !power_good_out) else $error("drive after reset");
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr > REG_REF |=> reg_rdata == 16'h0000) else $error("hole not zero");
    target_rdbk_a: assert property (
        reg_wr && reg_addr == REG_TARGET ##1 reg_rd && reg_addr == REG_TARGET
        |=> reg_rdata[VW-1:0] == $past(reg_wdata[VW-1:0], 2)) else $error("target lost");
    pg_after_drive_a: assert property (
        $rose(power_good_out) |-> $past(high_drive_en)) else $error("good before ramp");
    pg_drive_a: assert property (
        power_good_out |-> high_drive_en && low_drive_en) else $error("good without drive");
    off_no_pg_a: assert property (
        !enable_in [*8] |=> !power_good_out) else $error("good while disabled");
    oc_stop_a: assert property (
        overcurrent_in [*8] |=> !high_drive_en) else $error("drive kept in overcurrent");
endmodule

// File: src/fault_policy.sv
// per-source fault response engine: applies one policy, counts retries
// assumes fault_in is already synchronised and tick_ms is a one-cycle pulse
`timescale 1ns/1ps
module fault_policy
    import seq_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // configuration and inputs
    input  wire fault_cfg_t cfg,
    input  wire logic       fault_in,
    input  wire logic       clear_ok,
    input  wire logic       regulating,
    input  wire logic       tick_ms,
    // results
    output logic            shut,
    output logic            may_restart,
    output logic            latched
);
    typedef enum logic [1:0] { F_IDLE, F_GRACE, F_WAIT, F_STOP } fstate_t;
    fstate_t    st_q, st_d;
    logic [7:0] tmr_q, tmr_d;
    logic [3:0] cnt_q, cnt_d;
    policy_t    pol;
    assign pol = policy_t'(cfg.policy);

    // next state of the response engine
    always_comb begin
        st_d  = st_q;
        tmr_d = tmr_q;
        cnt_d = cnt_q;
        if (regulating && st_q == F_IDLE)
            cnt_d = 4'h0;                                       // R22
        if (tick_ms && tmr_q != 8'h00)
            tmr_d = tmr_q - 8'h01;
        case (st_q)
            F_IDLE: begin
                if (fault_in) begin
                    case (pol)
                        POL_IGNORE:    st_d = F_IDLE;
                        POL_DELAY_OFF: begin
                            st_d  = F_GRACE;
                            tmr_d = cfg.dly_ms;
                        end
                        POL_RETRY_INF, POL_RETRY_CNT: begin
                            st_d  = F_WAIT;
                            tmr_d = cfg.dly_ms;
                        end
                        default:       st_d = F_WAIT;           // immediate, auto re-enable
                    endcase
                end
            end
            F_GRACE: begin
                // runs on through the grace time, stops only if still faulty
                if (!fault_in)
                    st_d = F_IDLE;
                else if (tmr_q == 8'h00)
                    st_d = F_STOP;
            end
            F_WAIT: begin
                if (tmr_q == 8'h00 && clear_ok) begin
                    if (pol == POL_RETRY_CNT && cnt_q >= cfg.count)
                        st_d = F_STOP;
                    else begin
                        st_d  = F_IDLE;
                        cnt_d = cnt_q + 4'h1;
                    end
                end else if (tmr_q == 8'h00 && pol != POL_IMMEDIATE)
                    tmr_d = cfg.dly_ms;                         // wait again, recheck
            end
            F_STOP:  st_d = F_STOP;
            default: st_d = F_IDLE;
        endcase
    end

    // registers; outputs derive from state so they stay glitch free
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q  <= F_IDLE;
            tmr_q <= 8'h00;
            cnt_q <= 4'h0;
        end else begin
            st_q  <= st_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
        end
    end

    assign shut        = (st_q == F_WAIT) || (st_q == F_STOP);
    assign may_restart = (st_q == F_IDLE);
    assign latched     = (st_q == F_STOP);
endmodule

// File: src/prebias_fault_tracking_seq.sv
// start-up sequencer: pre-bias, ramp, tracking, and fault responses
// assumes analog codes arrive from converters on other clocks; enable from a pin
`timescale 1ns/1ps
// Operation
// R1 - sample output before any ramp
// R2 - below target: start from sample, ramp up
// R3 - scale slope so total ramp time fixed
// R4 - above target: hold sampled level duty
// R5 - after ramp assert power good, settle down
// R6 - sample over limit: overvoltage fault, no start
// R7 - no pre-bias with sharing plus tracking
// R8 - overcurrent applies selected five policies
// R9 - default overcurrent: shutdown, auto re-enable
// R10 - die temperature limit, default 125, programmable
// R11 - over-temperature uses same five policies
// R12 - temperature restart below limit minus 15
// R13 - default over-temperature: shutdown, auto re-enable
// R14 - tracking uses reference input as target
// R15 - coincident or ratiometric, default 50 percent
// R16 - group master not tracking, delay 10ms
// R17 - tracking ignores own delay and ramp
// R18 - group enables tied to one source
// R19 - host configures tracking via bus command
// R20 - host disables alternate ramp features first
// R21 - overvoltage: shutdown-retry or low side hold
// R22 - per-source policy, counter cleared at regulation
module prebias_fault_tracking_seq
    import seq_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [15:0]        reg_rdata,
    // analog side
    input  wire logic          enable_in,
    input  wire logic [VW-1:0] vout_sense,
    input  wire logic [VW-1:0] tracking_reference_in,
    input  wire logic [7:0]    die_temp,
    input  wire logic          overcurrent_in,
    // converter control
    output logic [VW-1:0]      vref_out,
    output logic               high_drive_en,
    output logic               low_drive_en,
    output logic               power_good_out
);
    // three-stage synchronisers for outside inputs
    logic [2:0] en_s_q, oc_s_q;
    logic       en_q, oc_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            en_s_q <= 3'b000;
            oc_s_q <= 3'b000;
            en_q   <= 1'b0;
            oc_q   <= 1'b0;
        end else begin
            en_s_q <= {en_s_q[1:0], enable_in};
            oc_s_q <= {oc_s_q[1:0], overcurrent_in};
            if (en_s_q[2] == en_s_q[1])
                en_q <= en_s_q[2];
            if (oc_s_q[2] == oc_s_q[1])
                oc_q <= oc_s_q[2];
        end
    end
    // analog codes: each sampled twice through registers; single-step error accepted
    logic [VW-1:0] vo_a_q, vo_q, tr_a_q, tr_q;
    logic [7:0]    tp_a_q, tp_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            vo_a_q <= '0;
            vo_q   <= '0;
            tr_a_q <= '0;
            tr_q   <= '0;
            tp_a_q <= '0;
            tp_q   <= '0;
        end else begin
            vo_a_q <= vout_sense;
            vo_q   <= vo_a_q;
            tr_a_q <= tracking_reference_in;
            tr_q   <= tr_a_q;
            tp_a_q <= die_temp;
            tp_q   <= tp_a_q;
        end
    end

    // configuration registers
    logic          share_q;
    logic [VW-1:0] target_q, ovlim_q;
    logic [15:0]   sdly_q, rtime_q;
    fault_cfg_t    occ_q, otc_q, ovc_q;
    logic [7:0]    otlim_q;
    logic          trk_en_q, trk_ratio_q;
    logic [6:0]    trk_pct_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            share_q     <= 1'b0;
            target_q    <= TARGET_RST;
            ovlim_q     <= OV_LIMIT_RST;
            sdly_q      <= START_DLY_RST;
            rtime_q     <= RAMP_TIME_RST;
            occ_q       <= FC_RST;                              // R9
            otc_q       <= FC_RST;                              // R13
            ovc_q       <= FC_RST;
            otlim_q     <= OT_LIMIT_RST;                        // R10
            trk_en_q    <= 1'b0;
            trk_ratio_q <= 1'b0;
            trk_pct_q   <= TRK_PCT_RST;                         // R15
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:      share_q  <= reg_wdata[CTRL_SHARE_BIT];
                REG_TARGET:    target_q <= reg_wdata[VW-1:0];
                REG_OV_LIMIT:  ovlim_q  <= reg_wdata[VW-1:0];
                REG_START_DLY: sdly_q   <= reg_wdata;
                REG_RAMP_TIME: rtime_q  <= reg_wdata;
                REG_OC_CFG:    occ_q    <= reg_wdata;           // R22
                REG_OT_CFG:    otc_q    <= reg_wdata;
                REG_OV_CFG:    ovc_q    <= reg_wdata;
                REG_OT_LIMIT:  otlim_q  <= reg_wdata[7:0];      // R10
                REG_TRACK_CFG: begin
                    trk_en_q    <= reg_wdata[TRK_EN_BIT];       // R19
                    trk_ratio_q <= reg_wdata[TRK_RATIO_BIT];
                    trk_pct_q   <= reg_wdata[TRK_PCT_LSB +: 7];
                end
                default: ;
            endcase
        end
    end

    // millisecond tick
    logic [CW-1:0] div_q, div_d;
    logic          tick;
    assign tick  = (div_q == CW'(MS_CYC - 1));
    assign div_d = tick ? '0 : div_q + 1'b1;
    always_ff @(posedge clk) begin
        if (rst)
            div_q <= '0;
        else
            div_q <= div_d;
    end

    // fault detectors
    logic ot_now, ot_cool, ov_now;
    assign ot_now  = (tp_q > otlim_q);                          // R10
    assign ot_cool = ({1'b0, tp_q} + {1'b0, OT_HYST_C}) < {1'b0, otlim_q}; // R12
    seq_state_t st_q, st_d;
    logic       oc_shut, oc_ok, oc_lat, ot_shut, ot_ok, ot_lat, ov_shut, ov_ok, ov_lat;
    logic       running;
    assign running = (st_q == ST_RUN);
    assign ov_now  = (st_q != ST_OFF && st_q != ST_DELAY && vo_q > ovlim_q);

    fault_policy u_oc (                                          // R8
        .clk         (clk),
        .rst         (rst),
        .cfg         (occ_q),
        .fault_in    (oc_q),
        .clear_ok    (!oc_q),
        .regulating  (running),
        .tick_ms     (tick),
        .shut        (oc_shut),
        .may_restart (oc_ok),
        .latched     (oc_lat)
    );
    fault_policy u_ot (                                          // R11
        .clk         (clk),
        .rst         (rst),
        .cfg         (otc_q),
        .fault_in    (ot_now),
        .clear_ok    (ot_cool),
        .regulating  (running),
        .tick_ms     (tick),
        .shut        (ot_shut),
        .may_restart (ot_ok),
        .latched     (ot_lat)
    );
    fault_policy u_ov (                                          // R21
        .clk         (clk),
        .rst         (rst),
        .cfg         (ovc_q),
        .fault_in    (ov_now),
        .clear_ok    (vo_q <= ovlim_q),
        .regulating  (running),
        .tick_ms     (tick),
        .shut        (ov_shut),
        .may_restart (ov_ok),
        .latched     (ov_lat)
    );
    logic any_shut, all_ok;
    assign any_shut = oc_shut || ot_shut || ov_shut || oc_lat || ot_lat || ov_lat;
    assign all_ok   = oc_ok && ot_ok && ov_ok;

    // sequencer state
    logic [15:0]   tmr_q, tmr_d;
    logic [VW-1:0] ref_q, ref_d, samp_q, samp_d;
    logic [VW+15:0] acc_q, acc_d;
    logic          pg_q, pg_d, hi_q, hi_d, lo_q, lo_d;
    logic          trk;
    logic [VW+6:0] ratio_prod;
    assign trk        = trk_en_q;
    assign ratio_prod = tr_q * trk_pct_q;

    // ramp step: whole span from the sample to the target spread over the full ramp time
    function automatic logic [VW+15:0] ramp_step(input logic [VW-1:0] from,
                                                 input logic [VW-1:0] to,
                                                 input logic [15:0]   ms);
        logic [VW+15:0] span;
        span = {(to - from), 16'h0000};
        ramp_step = (ms == 16'h0000) ? span : span / {{VW{1'b0}}, ms};
    endfunction

    always_comb begin
        st_d   = st_q;
        tmr_d  = tmr_q;
        ref_d  = ref_q;
        samp_d = samp_q;
        acc_d  = acc_q;
        pg_d   = pg_q;
        hi_d   = hi_q;
        lo_d   = lo_q;
        if (tick && tmr_q != 16'h0000)
            tmr_d = tmr_q - 16'h0001;
        case (st_q)
            ST_OFF: begin
                hi_d = 1'b0;
                lo_d = 1'b0;
                pg_d = 1'b0;
                if (en_q && all_ok) begin
                    st_d  = ST_DELAY;
                    tmr_d = trk ? 16'h0000 : sdly_q;            // R17
                end
            end
            ST_DELAY: begin
                samp_d = vo_q;                                  // R1
                if (!en_q)
                    st_d = ST_OFF;
                else if (tmr_q == 16'h0000) begin
                    hi_d = 1'b1;
                    lo_d = 1'b1;
                    if (trk) begin
                        st_d  = ST_RUN;                          // R7 R14
                        ref_d = trk_ratio_q ? ratio_prod[VW+6:7] : tr_q;
                    end else if (vo_q > ovlim_q) begin
                        st_d = ST_FAULT;                         // R6
                        hi_d = 1'b0;
                        lo_d = 1'b0;
                    end else if (vo_q >= target_q) begin
                        st_d  = ST_HOLD;                         // R4
                        ref_d = vo_q;
                        tmr_d = rtime_q;
                    end else begin
                        st_d  = ST_RAMP;                         // R2
                        ref_d = vo_q;
                        acc_d = {vo_q, 16'h0000};
                        tmr_d = rtime_q;
                    end
                end
            end
            ST_RAMP: begin
                if (tick)
                    acc_d = acc_q + ramp_step(samp_q, target_q, rtime_q); // R3
                ref_d = (acc_q[VW+15:16] > target_q) ? target_q : acc_q[VW+15:16];
                if (tmr_q == 16'h0000) begin
                    ref_d = target_q;
                    st_d  = ST_RUN;
                    pg_d  = 1'b1;                                // R5
                end
            end
            ST_HOLD: begin
                if (tmr_q == 16'h0000) begin
                    pg_d = 1'b1;                                 // R5
                    st_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (tick && ref_q > target_q)
                    ref_d = ref_q - 1'b1;                        // R5
                if (ref_q <= target_q)
                    st_d = ST_RUN;
            end
            ST_RUN: begin
                if (trk)                                         // R15
                    ref_d = trk_ratio_q ? ratio_prod[VW+6:7] : tr_q;
                if (!en_q && !trk)
                    st_d = ST_OFF;
            end
            ST_FAULT: begin
                pg_d     = 1'b0;
                if (ovc_q.policy == 3'(POL_RETRY_CNT) || ovc_q.policy == 3'(POL_RETRY_INF))
                    lo_d = 1'b1;                                 // R21
                if (!ov_shut && ov_ok && vo_q <= ovlim_q)
                    st_d = ST_OFF;
            end
            default: st_d = ST_OFF;
        endcase
        // tracking follows its reference to zero rather than stopping abruptly
        if (trk && !en_q && st_q == ST_RUN && tr_q == '0)
            st_d = ST_OFF;                                       // R17
        if (any_shut && st_q != ST_OFF && st_q != ST_FAULT) begin
            st_d = ST_OFF;                                       // R9
            hi_d = 1'b0;
            lo_d = 1'b0;
            pg_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= ST_OFF;
            tmr_q  <= 16'h0000;
            ref_q  <= '0;
            samp_q <= '0;
            acc_q  <= '0;
            pg_q   <= 1'b0;
            hi_q   <= 1'b0;
            lo_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            ref_q  <= ref_d;
            samp_q <= samp_d;
            acc_q  <= acc_d;
            pg_q   <= pg_d;
            hi_q   <= hi_d;
            lo_q   <= lo_d;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    logic [15:0] rd_q, rd_d;
    always_comb begin
        rd_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:      rd_d = {15'h0000, share_q};
                REG_TARGET:    rd_d = {4'h0, target_q};
                REG_OV_LIMIT:  rd_d = {4'h0, ovlim_q};
                REG_START_DLY: rd_d = sdly_q;
                REG_RAMP_TIME: rd_d = rtime_q;
                REG_OC_CFG:    rd_d = occ_q;
                REG_OT_CFG:    rd_d = otc_q;
                REG_OV_CFG:    rd_d = ovc_q;
                REG_OT_LIMIT:  rd_d = {8'h00, otlim_q};
                REG_TRACK_CFG: rd_d = {1'b0, trk_pct_q, 6'h00, trk_ratio_q, trk_en_q};
                REG_STATUS:    rd_d = {6'h00, oc_lat, ot_lat, ov_lat, ov_shut, ot_shut,
                                       oc_shut, 1'b0, st_q};
                REG_REF:       rd_d = {4'h0, ref_q};
                default:       rd_d = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (rst)
            rd_q <= 16'h0000;
        else
            rd_q <= rd_d;
    end

    assign reg_rdata      = rd_q;
    assign vref_out       = ref_q;
    assign high_drive_en  = hi_q;
    assign low_drive_en   = lo_q;
    assign power_good_out = pg_q;
endmodule
